// ---- design/ubde_cfg.svh ----
// Purpose: constants for the buffer descriptor engine
// Assumes: included by the engine and the testbench
// Notes:   offsets are register port byte addresses
`ifndef UBDE_CFG_SVH
`define UBDE_CFG_SVH
`define REG_BASE_LO     5'h00
`define REG_BASE_MID    5'h04
`define REG_BASE_HI     5'h08
`define REG_MODE        5'h0c
`define REG_EP_EN       5'h10
`define REG_STATUS      5'h14
`define REG_TRN_FIFO    5'h18
`define MODE_HOST_BIT   0
`define MODE_LS_BIT     1
`define STS_DONE_BIT    16
`define STS_OVF_BIT     17
`define W0_OFS          3'h0
`define W1_OFS          3'h4
`define F_OWN           7
`define F_DATA          6
`define F_KEEP          5
`define F_HOLD          4
`define F_DTS           3
`define F_STALL         2
`define F_PID_LO        2
`define F_CNT_LO        16
`define PID_OUT         4'h1
`define PID_IN          4'h9
`define PID_SETUP       4'hd
`define PID_ACK         4'h2
`define PID_NAK         4'ha
`define PID_STALL       4'he
`define PID_DATA0       4'h3
`define PID_DATA1       4'hb
`define MAX_EP          16
`endif

// ---- design/ubde_pkg.sv ----
// Purpose: types for the buffer descriptor engine
// Assumes: ubde_cfg.svh holds the numeric constants
// Notes:   all engine state lives in ubde_state_t
package ubde_pkg;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_RD0  = 4'b0010,
    S_RD1  = 4'b0100,
    S_DATA = 4'b1000
  } ubde_st_t;

  typedef struct packed {
    logic       own;
    logic       data;
    logic       keep;
    logic       hold;
    logic       toggle_sync_enable;
    logic       stall;
    logic [9:0] count;
  } ubde_ctl_t;

  typedef struct packed {
    ubde_st_t    st;
    logic        wb;
    logic [3:0]  ep;
    logic        dir;
    logic        par;
    logic [3:0]  tok;
    ubde_ctl_t   ctl;
    logic [9:0]  cnt;
    logic        ovf;
    logic [31:0] pp;
    logic [22:0] base;
    logic        host;
    logic        ls;
    logic [15:0] ep_en;
    logic [15:0] stalled;
    logic        done;
    logic        ovf_flag;
    logic [7:0]  fifo;
    logic        mem_req;
    logic        mem_we;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
    logic [31:0] dma_addr;
    logic        dma_en;
    logic        xfer_go;
    logic        xfer_tx;
    logic [3:0]  xfer_pid;
    logic [9:0]  xfer_count;
    logic        hs_valid;
    logic [3:0]  hs_pid;
    logic [31:0] rdata;
    logic        busy;
  } ubde_state_t;
endpackage

// ---- design/ubde_engine.sv ----
// Purpose: USB endpoint buffer descriptor engine
// Assumes: token/data events from the serial engine, one memory master
// Notes:   module reset never touches the table in memory
// Function
// - full speed both roles; low speed only while host
// - entry is 8 bytes: status word at +0, buffer address at +4
// - four entries per endpoint, up to 16 endpoints, 64 entries
// - entry address is base, endpoint, direction, parity, low bits
// - direction bit 1 for transmit, 0 for receive, per role
// - parity picks odd or even; alternates on each completion write-back
// - ownership bit 1 gives entry to module, else fields ignored
// - completion writes ownership bit back to zero
// - entry valid only with endpoint enabled; reset leaves table
// - count field is limit on entry, actual bytes on completion
// - data bit sets tx toggle; records received toggle
// - toggle sync enabled drops packets with wrong toggle
// - keep bit retains entry, no status or done update
// - address hold stops buffer address advancing
// - stall bit gives STALL in function mode, entry unchanged, stalled flag set
// - completion writes token pid into bits 5-2
// - host mode writes returned pid or status there
// - host mode uses endpoint 0 entries only
// - counts 0..1023; excess bytes flag overflow, truncated
// - unowned entry answers NAK in function mode
`timescale 1ns/100ps
`include "ubde_cfg.svh"
module ubde_engine
  import ubde_pkg::*;
#(
  parameter int NUM_EP = `MAX_EP
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic [4:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [31:0] o_reg_rdata,
  input  wire logic        i_tok_valid,
  input  wire logic [3:0]  i_tok_pid,
  input  wire logic [3:0]  i_tok_ep,
  input  wire logic        i_byte_stb,
  input  wire logic        i_data_done,
  input  wire logic [3:0]  i_rx_pid,
  input  wire logic [3:0]  i_host_pid,
  output logic             o_mem_req,
  output logic             o_mem_we,
  output logic      [31:0] o_mem_addr,
  output logic      [31:0] o_mem_wdata,
  input  wire logic        i_mem_ack,
  input  wire logic [31:0] i_mem_rdata,
  output logic      [31:0] o_dma_addr,
  output logic             o_dma_en,
  output logic             o_xfer_go,
  output logic             o_xfer_tx,
  output logic      [3:0]  o_xfer_pid,
  output logic      [9:0]  o_xfer_count,
  output logic             o_hs_valid,
  output logic      [3:0]  o_hs_pid,
  output logic             o_busy,
  output logic             o_low_speed
);

  initial begin
    if (NUM_EP < 1 || NUM_EP > `MAX_EP) $error("NUM_EP must lie in 1..16");
  end

  // entry address: base, endpoint, direction, parity, low bits
  function automatic logic [31:0] entry_addr(input logic [22:0] base,
    input logic [3:0] ep, input logic dir, input logic par,
    input logic [2:0] lo);
    entry_addr = {base, ep, dir, par, lo};
  endfunction

  // host sends on SETUP/OUT, a function sends on IN
  function automatic logic tok_is_tx(input logic [3:0] pid,
                                     input logic       host);
    tok_is_tx = host ? (pid != `PID_IN) : (pid == `PID_IN);
  endfunction

  ubde_state_t r_reg;
  ubde_state_t r_next;

  logic [4:0] pp_idx;
  logic       ep_ok;
  logic       tog_bad;
  logic [3:0] pid_wb;
  logic       data_wb;

  assign pp_idx  = {r_reg.ep, r_reg.dir};
  assign ep_ok   = r_reg.ep_en[r_reg.ep] && (32'(r_reg.ep) < NUM_EP);
  assign tog_bad = !r_reg.dir && r_reg.ctl.toggle_sync_enable &&
                   ((i_rx_pid == `PID_DATA1) != r_reg.ctl.data);
  assign pid_wb  = r_reg.host ? i_host_pid : r_reg.tok;
  assign data_wb = r_reg.dir ? r_reg.ctl.data :
                   (i_rx_pid == `PID_DATA1);

  always_comb begin
    r_next          = r_reg;
    r_next.xfer_go  = 1'b0;
    r_next.hs_valid = 1'b0;
    r_next.rdata    = '0;

    // register port
    if (i_reg_wr) begin
      case (i_reg_addr)
        `REG_BASE_LO:  r_next.base[7:0]   = i_reg_wdata[7:0];
        `REG_BASE_MID: r_next.base[15:8]  = i_reg_wdata[7:0];
        `REG_BASE_HI:  r_next.base[22:16] = i_reg_wdata[6:0];
        `REG_MODE: begin
          r_next.host = i_reg_wdata[`MODE_HOST_BIT];
          r_next.ls   = i_reg_wdata[`MODE_LS_BIT] & r_next.host;
        end
        `REG_EP_EN:    r_next.ep_en = i_reg_wdata[15:0];
        `REG_STATUS: begin
          // write one to clear; a same-cycle set below still wins
          r_next.stalled  = r_reg.stalled & ~i_reg_wdata[15:0];
          r_next.done     = r_reg.done & ~i_reg_wdata[`STS_DONE_BIT];
          r_next.ovf_flag = r_reg.ovf_flag &
                            ~i_reg_wdata[`STS_OVF_BIT];
        end
        default: ;
      endcase
    end
    if (i_reg_rd) begin
      case (i_reg_addr)
        `REG_BASE_LO:  r_next.rdata = {24'h0, r_reg.base[7:0]};
        `REG_BASE_MID: r_next.rdata = {24'h0, r_reg.base[15:8]};
        `REG_BASE_HI:  r_next.rdata = {25'h0, r_reg.base[22:16]};
        `REG_MODE:     r_next.rdata = {30'h0, r_reg.ls, r_reg.host};
        `REG_EP_EN:    r_next.rdata = {16'h0, r_reg.ep_en};
        `REG_STATUS:   r_next.rdata = {14'h0, r_reg.ovf_flag,
                                       r_reg.done, r_reg.stalled};
        `REG_TRN_FIFO: begin
          r_next.rdata   = {24'h0, r_reg.fifo};
          r_next.fifo[0] = 1'b0;
        end
        default:       r_next.rdata = '0;
      endcase
    end

    case (r_reg.st)
      S_IDLE: begin
        if (i_tok_valid) begin
          r_next.ep  = r_reg.host ? 4'h0 : i_tok_ep;
          r_next.tok = i_tok_pid;
          r_next.dir = tok_is_tx(i_tok_pid, r_reg.host);
          r_next.par = r_reg.pp[{r_next.ep, r_next.dir}];
          r_next.mem_req  = 1'b1;
          r_next.mem_we   = 1'b0;
          r_next.mem_addr = entry_addr(r_reg.base, r_next.ep,
                            r_next.dir, r_next.par, `W0_OFS);
          r_next.st = S_RD0;
        end
      end
      S_RD0: begin
        if (i_mem_ack) begin
          r_next.mem_req = 1'b0;
          r_next.ctl.own   = i_mem_rdata[`F_OWN];
          r_next.ctl.data  = i_mem_rdata[`F_DATA];
          r_next.ctl.keep  = i_mem_rdata[`F_KEEP];
          r_next.ctl.hold  = i_mem_rdata[`F_HOLD];
          r_next.ctl.toggle_sync_enable   = i_mem_rdata[`F_DTS];
          r_next.ctl.stall = i_mem_rdata[`F_STALL];
          r_next.ctl.count = i_mem_rdata[`F_CNT_LO +: 10];
          r_next.st = S_IDLE;
          if (!ep_ok || !i_mem_rdata[`F_OWN]) begin
            // other fields are ignored while software owns it
            r_next.hs_valid = !r_reg.host;
            r_next.hs_pid   = `PID_NAK;
          end else if (i_mem_rdata[`F_STALL]) begin
            // entry left untouched, no write back
            r_next.hs_valid = !r_reg.host;
            r_next.hs_pid   = `PID_STALL;
            r_next.stalled[r_reg.ep] = 1'b1;
          end else begin
            r_next.mem_req  = 1'b1;
            r_next.mem_addr = entry_addr(r_reg.base, r_reg.ep,
                              r_reg.dir, r_reg.par, `W1_OFS);
            r_next.st = S_RD1;
          end
        end
      end
      S_RD1: begin
        if (i_mem_ack) begin
          r_next.mem_req    = 1'b0;
          r_next.dma_addr   = i_mem_rdata;
          r_next.dma_en     = 1'b1;
          r_next.cnt        = '0;
          r_next.ovf        = 1'b0;
          r_next.xfer_go    = 1'b1;
          r_next.xfer_tx    = r_reg.dir;
          r_next.xfer_pid   = r_reg.ctl.data ? `PID_DATA1
                                             : `PID_DATA0;
          r_next.xfer_count = r_reg.ctl.count;
          r_next.st = S_DATA;
        end
      end
      S_DATA: begin
        if (r_reg.wb) begin
          if (i_mem_ack) begin
            r_next.mem_req = 1'b0;
            r_next.wb      = 1'b0;
            r_next.pp[pp_idx] = !r_reg.par;
            r_next.done    = 1'b1;
            r_next.fifo    = {1'b0, r_reg.par, r_reg.dir,
                              r_reg.ep, 1'b1};
            r_next.st      = S_IDLE;
          end
        end else if (i_byte_stb && r_reg.dma_en) begin
          if (r_reg.cnt < r_reg.ctl.count) begin
            r_next.cnt = r_reg.cnt + 10'h001;
            if (!r_reg.ctl.hold)
              r_next.dma_addr = r_reg.dma_addr + 32'h1;
          end else begin
            // surplus bytes are dropped, buffer never overrun
            r_next.ovf      = 1'b1;
            r_next.ovf_flag = 1'b1;
            r_next.dma_en   = 1'b0;
          end
        end else if (i_data_done) begin
          r_next.dma_en = 1'b0;
          if (tog_bad) begin
            r_next.hs_valid = !r_reg.host;
            r_next.hs_pid   = `PID_NAK;
            r_next.st       = S_IDLE;
          end else begin
            r_next.hs_valid = !r_reg.host && !r_reg.dir;
            r_next.hs_pid   = `PID_ACK;
            if (r_reg.ctl.keep) begin
              r_next.st = S_IDLE;
            end else begin
              r_next.wb        = 1'b1;
              r_next.mem_req   = 1'b1;
              r_next.mem_we    = 1'b1;
              r_next.mem_addr  = entry_addr(r_reg.base, r_reg.ep,
                                 r_reg.dir, r_reg.par, `W0_OFS);
              r_next.mem_wdata = {6'h00, r_reg.cnt, 8'h00,
                                  1'b0, data_wb, pid_wb,
                                  2'b00};
            end
          end
        end
      end
      default: r_next.st = S_IDLE;
    endcase
    r_next.busy = (r_next.st != S_IDLE);
  end

  // table in memory is never written from reset
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r_reg    <= '0;
      r_reg.st <= S_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_reg_rdata  = r_reg.rdata;
  assign o_mem_req    = r_reg.mem_req;
  assign o_mem_we     = r_reg.mem_we;
  assign o_mem_addr   = r_reg.mem_addr;
  assign o_mem_wdata  = r_reg.mem_wdata;
  assign o_dma_addr   = r_reg.dma_addr;
  assign o_dma_en     = r_reg.dma_en;
  assign o_xfer_go    = r_reg.xfer_go;
  assign o_xfer_tx    = r_reg.xfer_tx;
  assign o_xfer_pid   = r_reg.xfer_pid;
  assign o_xfer_count = r_reg.xfer_count;
  assign o_hs_valid   = r_reg.hs_valid;
  assign o_hs_pid     = r_reg.hs_pid;
  assign o_busy       = r_reg.busy;
  // low speed only sticks when written together with host mode
  assign o_low_speed  = r_reg.ls;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_unowned_fetch;
    r_reg.st == S_RD0 && i_mem_ack && !i_mem_rdata[`F_OWN]
      && !r_reg.host;
  endsequence

  sequence s_stall_fetch;
    r_reg.st == S_RD0 && i_mem_ack && i_mem_rdata[`F_OWN]
      && i_mem_rdata[`F_STALL] && ep_ok;
  endsequence

  property p_entry_addr;
    r_reg.st == S_IDLE && i_tok_valid |=>
      o_mem_addr[2:0] == 3'h0 && o_mem_addr[8:5] == r_reg.ep
      && o_mem_addr[31:9] == r_reg.base;
  endproperty
  a_entry_addr: assert property (p_entry_addr)
    else $error("entry address badly formed");

  property p_host_ep0;
    r_reg.host && r_reg.st == S_IDLE && i_tok_valid |=>
      r_reg.ep == 4'h0;
  endproperty
  a_host_ep0: assert property (p_host_ep0)
    else $error("host mode used non-zero endpoint");

  property p_nak_unowned;
    s_unowned_fetch |=> o_hs_valid && o_hs_pid == `PID_NAK
      && !o_mem_req;
  endproperty
  a_nak_unowned: assert property (p_nak_unowned)
    else $error("unowned entry not answered with NAK");

  property p_stall;
    s_stall_fetch |=> r_reg.stalled[$past(r_reg.ep)]
      && r_reg.st == S_IDLE && !o_mem_we;
  endproperty
  a_stall: assert property (p_stall)
    else $error("stall entry not handled");

  property p_release;
    o_mem_req && o_mem_we |-> !o_mem_wdata[`F_OWN]
      && o_mem_wdata[`F_CNT_LO +: 10] == r_reg.cnt;
  endproperty
  a_release: assert property (p_release)
    else $error("write back keeps ownership or count");

  property p_hold;
    r_reg.st == S_DATA && !r_reg.wb && i_byte_stb && r_reg.dma_en
      && r_reg.ctl.hold |=> $stable(o_dma_addr);
  endproperty
  a_hold: assert property (p_hold)
    else $error("buffer address moved while held");

  property p_overflow;
    r_reg.st == S_DATA && !r_reg.wb && i_byte_stb && r_reg.dma_en
      && r_reg.cnt == r_reg.ctl.count |=>
      r_reg.ovf_flag && r_reg.ovf && !o_dma_en && $stable(r_reg.cnt);
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("overflow not flagged or not truncated");

  property p_pingpong;
    r_reg.st == S_DATA && r_reg.wb && i_mem_ack |=>
      r_reg.pp[$past(pp_idx)] != $past(r_reg.par);
  endproperty
  a_pingpong: assert property (p_pingpong)
    else $error("ping-pong parity not alternated");

  property p_keep;
    r_reg.st == S_DATA && !r_reg.wb && !i_byte_stb && i_data_done
      && !tog_bad && r_reg.ctl.keep |=>
      r_reg.st == S_IDLE && !o_mem_req && $stable(r_reg.done);
  endproperty
  a_keep: assert property (p_keep)
    else $error("kept entry was handed back");

  property p_low_speed;
    o_low_speed |-> r_reg.host;
  endproperty
  a_low_speed: assert property (p_low_speed)
    else $error("low speed outside host mode");

endmodule

// ---- testbench/ubde_mem_model.sv ----
// Purpose: shared system memory holding descriptor entries
// Assumes: one request at a time, held until acknowledged
// Notes:   i_lat stretches answers; idle read data toggles
`timescale 1ns/100ps
module ubde_mem_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic [31:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic [1:0]  i_lat,
  output logic             o_ack,
  output logic      [31:0] o_rdata
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] rd_q [$];
  logic [31:0] wa_q [$];
  logic [31:0] wd_q [$];
  int          wait_c;
  // memory content survives reset, as the table must
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ack   <= 1'b0;
      o_rdata <= 32'h0;
      wait_c  <= 0;
    end else if (i_req && !o_ack && wait_c < i_lat) begin
      wait_c  <= wait_c + 1;
      o_rdata <= ~o_rdata;
    end else if (i_req && !o_ack) begin
      o_ack  <= 1'b1;
      wait_c <= 0;
      if (i_we) begin
        mem[i_addr] = i_wdata;
        wa_q.push_back(i_addr);
        wd_q.push_back(i_wdata);
      end else begin
        rd_q.push_back(i_addr);
        o_rdata <= mem.exists(i_addr) ? mem[i_addr] : ~o_rdata;
      end
    end else begin
      o_ack   <= 1'b0;
      o_rdata <= ~o_rdata;
    end
  end
endmodule

// ---- testbench/test_usb_buffer_descriptor_engine.sv ----
// Purpose: self-checking bench for the descriptor engine
// Assumes: memory model answers entry fetches and write-backs
// Notes:   expectations come from a small model kept in the bench
`timescale 1ns/100ps
`include "ubde_cfg.svh"
module test_usb_buffer_descriptor_engine;
  logic        i_sys_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [4:0]  i_reg_addr = 5'h0;
  logic [31:0] i_reg_wdata = 32'h0;
  logic        i_reg_wr = 1'b0;
  logic        i_reg_rd = 1'b0;
  logic        i_tok_valid = 1'b0;
  logic [3:0]  i_tok_pid = 4'h0;
  logic [3:0]  i_tok_ep = 4'h0;
  logic        i_byte_stb = 1'b0;
  logic        i_data_done = 1'b0;
  logic [3:0]  i_rx_pid = 4'h0;
  logic [3:0]  i_host_pid = 4'h0;
  logic [1:0]  lat = 2'h0;
  logic [31:0] o_reg_rdata, o_mem_addr, o_mem_wdata, o_dma_addr, i_mem_rdata;
  logic        o_mem_req, o_mem_we, i_mem_ack, o_dma_en, o_xfer_go;
  logic        o_xfer_tx, o_hs_valid, o_busy, o_low_speed;
  logic [3:0]  o_xfer_pid, o_hs_pid, hs_p, g_pid;
  logic [9:0]  o_xfer_count, g_cnt;
  logic [31:0] lfsr_v = 32'hee1b;
  logic [31:0] par_m = 32'h0;
  logic [31:0] g_dma;
  logic [22:0] base_m;
  logic [15:0] en_m = 16'h8005;
  logic [15:0] stl_m = 16'h0;
  logic [6:0]  fifo_m = 7'h0;
  logic        host_m = 1'b0;
  logic        done_m = 1'b0;
  logic        ovf_m = 1'b0;
  logic        g_tx;
  int          miscompares = 0;
  int          checks = 0;
  int          go_n = 0;
  int          hs_n = 0;

  ubde_engine #(.NUM_EP(16)) dut_u (
    .i_sys_clk, .i_rst_n, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
    .o_reg_rdata, .i_tok_valid, .i_tok_pid, .i_tok_ep, .i_byte_stb,
    .i_data_done, .i_rx_pid, .i_host_pid, .o_mem_req, .o_mem_we,
    .o_mem_addr, .o_mem_wdata, .i_mem_ack, .i_mem_rdata, .o_dma_addr,
    .o_dma_en, .o_xfer_go, .o_xfer_tx, .o_xfer_pid, .o_xfer_count,
    .o_hs_valid, .o_hs_pid, .o_busy, .o_low_speed
  );
  ubde_mem_model mem_u (
    .i_sys_clk, .i_rst_n, .i_req(o_mem_req), .i_we(o_mem_we),
    .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .i_lat(lat),
    .o_ack(i_mem_ack), .o_rdata(i_mem_rdata)
  );

  always #2.5 i_sys_clk = ~i_sys_clk;

  always @(negedge i_sys_clk) begin
    if (o_xfer_go === 1'b1) begin
      go_n++;
      g_tx  = o_xfer_tx;
      g_pid = o_xfer_pid;
      g_cnt = o_xfer_count;
      g_dma = o_dma_addr;
    end
    if (o_hs_valid === 1'b1) begin
      hs_n++;
      hs_p = o_hs_pid;
    end
  end

  function automatic logic [31:0] rnd();
    lfsr_v = {lfsr_v[30:0], lfsr_v[31] ^ lfsr_v[21] ^ lfsr_v[1] ^ lfsr_v[0]};
    return lfsr_v;
  endfunction
  function automatic logic [31:0] cw(input logic [9:0] c,
                                     input logic [5:0] f);
    return {6'h0, c, 8'h0, f, 2'h0};
  endfunction

  task automatic tally_and_finish();
    if (miscompares == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp);
    cmp_word({31'h0, got}, {31'h0, exp});
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_reg_wr    <= 1'b1;
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rd_cmp(input logic [4:0] a, input logic [31:0] exp);
    @(posedge i_sys_clk);
    i_reg_rd   <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b0;
    @(negedge i_sys_clk);
    cmp_word(o_reg_rdata, exp);
  endtask
  task automatic chk_regs();
    rd_cmp(`REG_STATUS, {14'h0, ovf_m, done_m, stl_m});
    rd_cmp(`REG_TRN_FIFO, {25'h0, fifo_m});
    fifo_m[0] = 1'b0;
  endtask

  task automatic txn(input logic [3:0] pid, input logic [3:0] ep,
                     input logic [31:0] ctl, input int nb,
                     input logic [3:0] rxp, input logic [3:0] hp);
    logic [3:0]  e;
    logic [3:0]  eh;
    logic        dir;
    logic        p;
    logic        ok;
    logic        wbx;
    logic [31:0] ea;
    logic [31:0] bufa;
    logic [31:0] wb;
    logic [9:0]  n;
    int          nr;
    int          nw;
    int          g0;
    int          h0;
    e    = host_m ? 4'h0 : ep;
    dir  = host_m ? (pid != `PID_IN) : (pid == `PID_IN);
    p    = par_m[{e, dir}];
    ea   = {base_m, e, dir, p, 3'h0};
    bufa = rnd();
    n    = (nb > ctl[25:16]) ? ctl[25:16] : 10'(nb);
    mem_u.mem[ea]     = ctl;
    mem_u.mem[ea + 4] = bufa;
    nr  = mem_u.rd_q.size();
    nw  = mem_u.wa_q.size();
    g0  = go_n;
    h0  = hs_n;
    ok  = ctl[`F_OWN] && en_m[e] && !ctl[`F_STALL];
    eh  = 4'h0;
    wbx = 1'b0;
    wb  = {6'h0, n, 8'h0, 1'b0, dir ? ctl[`F_DATA] : (rxp == `PID_DATA1),
           host_m ? hp : pid, 2'h0};
    @(posedge i_sys_clk);
    i_tok_valid <= 1'b1;
    i_tok_pid   <= pid;
    i_tok_ep    <= ep;
    lat         <= bufa[1:0];
    @(posedge i_sys_clk);
    i_tok_valid <= 1'b0;
    for (int k = 0; k < 60 && go_n == g0 && (k < 2 || o_busy); k++)
      @(negedge i_sys_clk);
    cmp_flag(go_n != g0, ok);
    if (go_n != g0) begin
      cmp_flag(g_tx, dir);
      cmp_word(g_cnt, ctl[25:16]);
      cmp_word(g_dma, bufa);
      if (dir) cmp_word(g_pid, ctl[`F_DATA] ? `PID_DATA1 : `PID_DATA0);
      repeat (nb) begin
        @(posedge i_sys_clk);
        i_byte_stb <= 1'b1;
        @(posedge i_sys_clk);
        i_byte_stb <= 1'b0;
      end
      @(negedge i_sys_clk);
      if (nb <= ctl[25:16])
        cmp_word(o_dma_addr, bufa + (ctl[`F_HOLD] ? 0 : nb));
      cmp_flag(o_dma_en, nb <= ctl[25:16]);
      @(posedge i_sys_clk);
      i_data_done <= 1'b1;
      i_rx_pid    <= rxp;
      i_host_pid  <= hp;
      @(posedge i_sys_clk);
      i_data_done <= 1'b0;
    end
    for (int k = 0; k < 60 && o_busy !== 1'b0; k++) @(negedge i_sys_clk);
    @(negedge i_sys_clk);
    if (!ctl[`F_OWN] || !en_m[e]) begin
      eh = `PID_NAK;
    end else if (ctl[`F_STALL]) begin
      eh = `PID_STALL;
      stl_m[e] = 1'b1;
    end else if (!dir && ctl[`F_DTS] && (rxp !=
             (ctl[`F_DATA] ? `PID_DATA1 : `PID_DATA0))) begin
      eh = `PID_NAK;
    end else begin
      if (!dir) eh = `PID_ACK;
      if (!ctl[`F_KEEP]) begin
        wbx = 1'b1;
        par_m[{e, dir}] = !p;
        done_m = 1'b1;
        ovf_m  = ovf_m | (nb > ctl[25:16]);
        fifo_m = {p, dir, e, 1'b1};
      end
    end
    cmp_word(mem_u.rd_q[nr], ea);
    if (ok) cmp_word(mem_u.rd_q[nr + 1], ea + 4);
    cmp_word(hs_n - h0, (eh != 4'h0 && !host_m) ? 1 : 0);
    if (hs_n != h0) cmp_word(hs_p, eh);
    cmp_word(mem_u.wa_q.size() - nw, wbx);
    if (wbx) cmp_word(mem_u.wa_q[nw], ea);
    if (wbx) cmp_word(mem_u.wd_q[nw], wb);
  endtask

  initial begin
    #100us;
    miscompares++;
    tally_and_finish();
  end

  initial begin
    repeat (10) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    rd_cmp(`REG_STATUS, 32'h0);
    rd_cmp(5'h1c, 32'h0);
    base_m = 23'(rnd());
    wr(`REG_BASE_LO, {24'h0, base_m[7:0]});
    wr(`REG_BASE_MID, {24'h0, base_m[15:8]});
    wr(`REG_BASE_HI, {25'h0, base_m[22:16]});
    wr(`REG_EP_EN, {16'h0, en_m});
    rd_cmp(`REG_EP_EN, {16'h0, en_m});
    rd_cmp(`REG_BASE_HI, {25'h0, base_m[22:16]});
    wr(`REG_MODE, 32'h2);
    @(negedge i_sys_clk);
    cmp_flag(o_low_speed, 1'b0);
    txn(`PID_SETUP, 4'h2, cw(10'h10, 6'b100000), 1 + rnd() % 8,
        `PID_DATA1, 4'h0);
    chk_regs();
    txn(`PID_OUT, 4'h2, cw(10'h10, 6'b100110), 4, `PID_DATA0, 4'h0);
    txn(`PID_OUT, 4'h2, cw(10'h10, 6'b110010), 3, `PID_DATA0, 4'h0);
    txn(`PID_IN, 4'hf, cw(10'h3, 6'b110000), 3, `PID_DATA0, 4'h0);
    txn(`PID_SETUP, 4'h0, cw(10'h8, 6'b000000), 0, 4'h0, 4'h0);
    txn(`PID_OUT, 4'h5, cw(10'h8, 6'b100000), 0, 4'h0, 4'h0);
    txn(`PID_IN, 4'h0, cw(10'h8, 6'b100001), 0, 4'h0, 4'h0);
    txn(`PID_OUT, 4'h0, cw(10'h8, 6'b101000), 2, `PID_DATA0, 4'h0);
    txn(`PID_OUT, 4'hf, cw(10'h2, 6'b100000), 3, `PID_DATA1, 4'h0);
    chk_regs();
    wr(`REG_STATUS, 32'h3ffff);
    stl_m  = 16'h0;
    done_m = 1'b0;
    ovf_m  = 1'b0;
    rd_cmp(`REG_STATUS, 32'h0);
    host_m = 1'b1;
    wr(`REG_MODE, 32'h3);
    rd_cmp(`REG_MODE, 32'h3);
    @(negedge i_sys_clk);
    cmp_flag(o_low_speed, 1'b1);
    txn(`PID_SETUP, 4'h7, cw(10'h8, 6'b100000), 8, 4'h0, `PID_ACK);
    txn(`PID_OUT, 4'h3, cw(10'h8, 6'b100000), 4, 4'h0, `PID_NAK);
    txn(`PID_IN, 4'h0, cw(10'h8, 6'b100000), 2, `PID_DATA1, 4'hf);
    txn(`PID_IN, 4'h9, cw(10'h8, 6'b100000), 0, `PID_DATA0, 4'h0);
    chk_regs();
    tally_and_finish();
  end
endmodule
